// [rlsb_defs.svh]
// Offsets, field positions, commands and reset values of the remote/local status block
`ifndef RLSB_DEFS_SVH
`define RLSB_DEFS_SVH

// Register indices; byte address is four times the index
`define RLSB_IDX_INT_TWO 8'h04
`define RLSB_IDX_AUX_CMD 8'h0A
`define RLSB_IDX_CHG_STATUS 8'h10
`define RLSB_ADDR_INT_TWO 8'h10
`define RLSB_ADDR_AUX_CMD 8'h28
`define RLSB_ADDR_CHG_STATUS 8'h40

// Field positions in status, mask and configuration
`define RLSB_BIT_LOCKOUT 5
`define RLSB_BIT_HOST_CTRL 4
`define RLSB_BIT_LOCKOUT_CHG 2
`define RLSB_BIT_HOST_CTRL_CHG 1
`define RLSB_BIT_RTL 0
`define RLSB_BIT_CLR_SELECT 0

// Auxiliary command codes
`define RLSB_CMD_PULSE_RTL 8'h05
`define RLSB_CMD_RTL 8'h0D
`define RLSB_CMD_CLR_LOCKOUT_CHG 8'h59
`define RLSB_CMD_CLR_HOST_CTRL_CHG 8'h5A
`define RLSB_CFG_I_PREFIX 4'hE

// Reset values
`define RLSB_RST_MASK_TWO 8'h00
`define RLSB_RST_CFG_I 8'hE0
`define RLSB_RST_DATA 32'h0000_0000

`endif

// [rlsb_pkg.sv]
// Types shared by the remote/local status block
package rlsb_pkg;

  // Remote/local interface function states
  typedef enum logic [1:0] {
    RLSB_LOCAL,
    RLSB_REMOTE,
    RLSB_LOCAL_LOCKOUT,
    RLSB_REMOTE_LOCKOUT
  } rlsb_state_e;

  typedef logic [7:0] rlsb_byte_t;

endpackage

// [rlsb_rl_fsm.sv]
// Remote/local state machine with registered lockout and remote state bits
`timescale 1ns/10ps
module rlsb_rl_fsm
  import rlsb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ren,
  input wire logic listen_addressed,
  input wire logic my_listen_addr,
  input wire logic llo_cmd,
  input wire logic gtl_cmd,
  input wire logic rtl,
  output logic lockout_q,
  output logic remote_q,
  output rlsb_state_e state_q
);

  rlsb_state_e state_d;
  logic gtl_here;

  // Go to local only counts while listen addressed
  assign gtl_here = gtl_cmd & listen_addressed;

  // Transition logic; loss of remote enable wins from every state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      RLSB_LOCAL: begin
        if (llo_cmd) begin
          state_d = RLSB_LOCAL_LOCKOUT;
        end else if (my_listen_addr && !rtl) begin
          state_d = RLSB_REMOTE;
        end
      end
      RLSB_REMOTE: begin
        if (llo_cmd) begin
          state_d = RLSB_REMOTE_LOCKOUT;
        end else if (gtl_here || rtl) begin
          state_d = RLSB_LOCAL;
        end
      end
      RLSB_LOCAL_LOCKOUT: begin
        // Lockout lets addressing pull remote even with rtl set
        if (my_listen_addr) begin
          state_d = RLSB_REMOTE_LOCKOUT;
        end
      end
      RLSB_REMOTE_LOCKOUT: begin
        if (gtl_here) begin
          state_d = RLSB_LOCAL_LOCKOUT;
        end
      end
    endcase
    if (!ren) begin
      state_d = RLSB_LOCAL;
    end
  end

  // State and decoded bits all come from flops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= RLSB_LOCAL;
      lockout_q <= 1'b0;
      remote_q <= 1'b0;
    end else begin
      state_q <= state_d;
      lockout_q <= (state_d == RLSB_LOCAL_LOCKOUT) || (state_d == RLSB_REMOTE_LOCKOUT);
      remote_q <= (state_d == RLSB_REMOTE) || (state_d == RLSB_REMOTE_LOCKOUT);
    end
  end

endmodule // rlsb_rl_fsm

// [rlsb_top.sv]
// Remote/local status block: APB registers, change flags, rtl message and interrupt
`timescale 1ns/10ps
`include "rlsb_defs.svh"
module rlsb_top
  import rlsb_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic REN_N,
  input wire logic LISTEN_ADDRESSED,
  input wire logic MY_LISTEN_ADDR,
  input wire logic LOCAL_LOCKOUT_CMD,
  input wire logic GO_TO_LOCAL_CMD,
  output logic LOCKOUT_FLAG,
  output logic HOST_CONTROLLED_FLAG,
  output logic RTL_ACTIVE,
  output logic IRQ
);

  // Remote enable pin synchroniser, three stages
  logic ren_s1_q;
  logic ren_s2_q;
  logic ren_s3_q;
  logic ren_q;

  // Bus handshake state
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Reset image of the configuration byte; the select bit is taken from it
  localparam rlsb_byte_t cfg_i_rst = `RLSB_RST_CFG_I;

  // Software visible state
  rlsb_byte_t mask_two_q;
  logic clr_select_q;
  logic lockout_chg_q;
  logic lockout_chg_d;
  logic host_ctrl_chg_q;
  logic host_ctrl_chg_d;
  logic rtl_hold_q;
  logic rtl_pulse_q;
  logic lockout_prev_q;
  logic host_ctrl_prev_q;
  logic irq_q;

  // State machine outputs and its rtl input
  logic lockout;
  logic host_ctrl;
  logic rtl;

  // Decode wires
  logic setup;
  logic access;
  logic wr_en;
  logic rd_en;
  logic hit_int_two;
  logic hit_aux;
  logic hit_chg;
  logic mapped;
  rlsb_byte_t wbyte;
  logic aux_wr;
  logic cfg_wr;
  logic cmd_pulse_rtl;
  logic cmd_rtl;
  logic cmd_clr_lockout;
  logic cmd_clr_host_ctrl;
  logic status_rd_clr;
  logic w1c_wr;
  logic lockout_set;
  logic host_ctrl_set;
  logic lockout_clr;
  logic host_ctrl_clr;
  rlsb_byte_t status_two;
  rlsb_byte_t chg_status;
  logic [31:0] rdata_mux;
  logic [31:0] rdata_next;
  logic ren_agree;
  logic mask_wr;
  logic rtl_pulse_d;
  logic rtl_hold_d;
  logic irq_d;

  // Second and third stages must agree; a one-clock glitch on the cable never gets through
  assign ren_agree = ~(ren_s2_q ^ ren_s3_q);

  // First stage is read only by the second; stages two and three vote
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ren_s1_q <= 1'b1;
      ren_s2_q <= 1'b1;
      ren_s3_q <= 1'b1;
      ren_q <= 1'b0;
    end else begin
      ren_s1_q <= REN_N;
      ren_s2_q <= ren_s1_q;
      ren_s3_q <= ren_s2_q;
      if (ren_agree) begin
        ren_q <= ~ren_s3_q;
      end
    end
  end

  // The rtl local message is the held level or the single pulse
  assign rtl = rtl_hold_q | rtl_pulse_q;

  // Remote/local interface function
  // State code left open; only the two decoded bits leave the block
  rlsb_rl_fsm u_fsm (
    .clk(CLK),
    .nrst(NRST),
    .ren(ren_q),
    .listen_addressed(LISTEN_ADDRESSED),
    .my_listen_addr(MY_LISTEN_ADDR),
    .llo_cmd(LOCAL_LOCKOUT_CMD),
    .gtl_cmd(GO_TO_LOCAL_CMD),
    .rtl(rtl),
    .lockout_q(lockout),
    .remote_q(host_ctrl),
    .state_q()
  );

  // APB phase decode; the slave never waits, so access ends in one cycle
  // Only PSTRB[0] qualifies a write, since every register is one byte wide
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE & pready_q;
  assign wr_en = access & PWRITE & PSTRB[0] & ~pslverr_q;
  assign rd_en = access & ~PWRITE & ~pslverr_q;

  // Address decode; only the three word addresses answer
  assign hit_int_two = (PADDR == `RLSB_ADDR_INT_TWO);
  assign hit_aux = (PADDR == `RLSB_ADDR_AUX_CMD);
  assign hit_chg = (PADDR == `RLSB_ADDR_CHG_STATUS);
  assign mapped = hit_int_two | hit_aux | hit_chg;
  assign wbyte = PWDATA[7:0];

  // Auxiliary port: the 0xEx pattern loads configuration, anything else is a command
  assign aux_wr = wr_en & hit_aux;
  assign cfg_wr = aux_wr & (wbyte[7:4] == `RLSB_CFG_I_PREFIX);
  assign cmd_pulse_rtl = aux_wr & (wbyte == `RLSB_CMD_PULSE_RTL);
  assign cmd_rtl = aux_wr & (wbyte == `RLSB_CMD_RTL);
  assign cmd_clr_lockout = aux_wr & (wbyte == `RLSB_CMD_CLR_LOCKOUT_CHG) & clr_select_q;
  assign cmd_clr_host_ctrl = aux_wr & (wbyte == `RLSB_CMD_CLR_HOST_CTRL_CHG) & clr_select_q;

  // Read of status clears only what that read reported, so nothing is lost
  assign status_rd_clr = rd_en & hit_int_two & ~clr_select_q;
  assign w1c_wr = wr_en & hit_chg;
  assign mask_wr = wr_en & hit_int_two;

  // Change detection against last cycle's state bits
  // References reset to the state bits' reset values, so reset shows no false change
  assign lockout_set = lockout ^ lockout_prev_q;
  assign host_ctrl_set = host_ctrl ^ host_ctrl_prev_q;

  // Clear sources for each change flag
  assign lockout_clr = cmd_clr_lockout
    | (status_rd_clr & prdata_q[`RLSB_BIT_LOCKOUT_CHG])
    | (w1c_wr & wbyte[`RLSB_BIT_LOCKOUT_CHG]);
  assign host_ctrl_clr = cmd_clr_host_ctrl
    | (status_rd_clr & prdata_q[`RLSB_BIT_HOST_CTRL_CHG])
    | (w1c_wr & wbyte[`RLSB_BIT_HOST_CTRL_CHG]);

  // A change in the clearing cycle keeps the flag set
  assign lockout_chg_d = lockout_set | (lockout_chg_q & ~lockout_clr);
  assign host_ctrl_chg_d = host_ctrl_set | (host_ctrl_chg_q & ~host_ctrl_clr);

  // Status register image: state bits and change flags, rest reads zero
  always_comb begin
    status_two = 8'h00;
    status_two[`RLSB_BIT_LOCKOUT] = lockout;
    status_two[`RLSB_BIT_HOST_CTRL] = host_ctrl;
    status_two[`RLSB_BIT_LOCKOUT_CHG] = lockout_chg_q;
    status_two[`RLSB_BIT_HOST_CTRL_CHG] = host_ctrl_chg_q;
  end

  // Write-one-to-clear image of the flags plus the rtl level
  always_comb begin
    chg_status = 8'h00;
    chg_status[`RLSB_BIT_LOCKOUT_CHG] = lockout_chg_q;
    chg_status[`RLSB_BIT_HOST_CTRL_CHG] = host_ctrl_chg_q;
    chg_status[`RLSB_BIT_RTL] = rtl;
  end

  // Read mux; command port reads as zero
  assign rdata_mux = hit_int_two ? {24'h00_0000, status_two} :
                     hit_chg ? {24'h00_0000, chg_status} :
                     `RLSB_RST_DATA;

  // Writes and unmapped reads capture zero, so no stale status leaks onto the bus
  assign rdata_next = (PWRITE || !mapped) ? `RLSB_RST_DATA : rdata_mux;

  // Answer registered in setup so outputs come straight from flops
  // PREADY rises in the access cycle only: zero wait states
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `RLSB_RST_DATA;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= rdata_next;
      end
    end
  end

  // Mask and status clear select; no enable bit ever stops the state machine
  // All eight mask bits are stored; only bits 2 and 1 gate the interrupt
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      mask_two_q <= `RLSB_RST_MASK_TWO;
      clr_select_q <= cfg_i_rst[`RLSB_BIT_CLR_SELECT];
    end else begin
      if (mask_wr) begin
        mask_two_q <= wbyte;
      end
      if (cfg_wr) begin
        clr_select_q <= wbyte[`RLSB_BIT_CLR_SELECT];
      end
    end
  end

  // Pulse refused while rtl already stands; the pulse command also drops the hold
  // The two commands are different bytes, so they never meet in one write
  assign rtl_pulse_d = cmd_pulse_rtl & ~rtl;
  assign rtl_hold_d = cmd_rtl | (rtl_hold_q & ~cmd_pulse_rtl);

  // Return to local: held by one command, one-cycle pulse and release by the other
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rtl_hold_q <= 1'b0;
      rtl_pulse_q <= 1'b0;
    end else begin
      rtl_pulse_q <= rtl_pulse_d;
      rtl_hold_q <= rtl_hold_d;
    end
  end

  // Change flags and their previous-state references
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      lockout_prev_q <= 1'b0;
      host_ctrl_prev_q <= 1'b0;
      lockout_chg_q <= 1'b0;
      host_ctrl_chg_q <= 1'b0;
    end else begin
      lockout_prev_q <= lockout;
      host_ctrl_prev_q <= host_ctrl;
      lockout_chg_q <= lockout_chg_d;
      host_ctrl_chg_q <= host_ctrl_chg_d;
    end
  end

  // Next flag values feed the level, so the interrupt rises with its flag
  assign irq_d = (lockout_chg_d & mask_two_q[`RLSB_BIT_LOCKOUT_CHG])
    | (host_ctrl_chg_d & mask_two_q[`RLSB_BIT_HOST_CTRL_CHG]);

  // Level interrupt from flags gated by their enables
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // The APB response, status flags and interrupt leave the block; no instrument bus line is driven
  // PRDATA holds between transfers; only PREADY marks the cycle it is valid
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign LOCKOUT_FLAG = lockout;
  assign HOST_CONTROLLED_FLAG = host_ctrl;
  assign RTL_ACTIVE = rtl_hold_q;
  assign IRQ = irq_q;

endmodule // rlsb_top

// [rlsb_top_chk.sv]
// Port-level assertions for the remote/local status block
`timescale 1ns/10ps
module rlsb_top_chk (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic PREADY,
  input wire logic REN_N,
  input wire logic MY_LISTEN_ADDR,
  input wire logic LOCAL_LOCKOUT_CMD,
  input wire logic LOCKOUT_FLAG,
  input wire logic HOST_CONTROLLED_FLAG,
  input wire logic RTL_ACTIVE,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Completed writes decoded per register; only the taking edge counts
  wire wr_done = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
  wire aux_wr = wr_done && (PADDR == 8'h28);
  wire mask_wr = wr_done && (PADDR == 8'h10);
  wire in_local = !LOCKOUT_FLAG && !HOST_CONTROLLED_FLAG;

  a_lockout_cause: assert property ($rose(LOCKOUT_FLAG) |-> $past(LOCAL_LOCKOUT_CMD))
    else $error("Lockout set without lockout command");
  a_lockout_exit: assert property ($fell(LOCKOUT_FLAG) |-> $past(REN_N, 2))
    else $error("Lockout left while remote enable held");
  a_remote_cause: assert property ($rose(HOST_CONTROLLED_FLAG) |-> $past(MY_LISTEN_ADDR))
    else $error("Remote entered without listen address");
  a_rtl_blocks: assert property (MY_LISTEN_ADDR && RTL_ACTIVE && in_local |=> !HOST_CONTROLLED_FLAG)
    else $error("Remote entered while return to local held");
  a_rtl_to_local: assert property (RTL_ACTIVE && HOST_CONTROLLED_FLAG && !LOCKOUT_FLAG |-> ##[1:2] !HOST_CONTROLLED_FLAG)
    else $error("Remote kept while return to local held");
  a_rtl_hold: assert property (aux_wr && PWDATA[7:0] == 8'h0D |=> RTL_ACTIVE)
    else $error("Held return to local not raised");
  a_rtl_release: assert property (aux_wr && PWDATA[7:0] == 8'h05 |=> !RTL_ACTIVE)
    else $error("Return to local still held after pulse command");
  a_mask_quiets: assert property (mask_wr && PWDATA[2:1] == 2'b00 |-> ##2 !IRQ)
    else $error("Interrupt with both change enables clear");
  a_ren_local: assert property (REN_N [*8] |-> in_local)
    else $error("Not local after remote enable released");

  // Main scenarios reached
  c_lockout: cover property ($rose(LOCKOUT_FLAG));
  c_irq: cover property ($rose(IRQ));
  c_rtl: cover property (aux_wr && PWDATA[7:0] == 8'h0D);
endmodule // rlsb_top_chk

bind rlsb_top rlsb_top_chk chk (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .REN_N(REN_N), .MY_LISTEN_ADDR(MY_LISTEN_ADDR),
  .LOCAL_LOCKOUT_CMD(LOCAL_LOCKOUT_CMD), .LOCKOUT_FLAG(LOCKOUT_FLAG), .HOST_CONTROLLED_FLAG(HOST_CONTROLLED_FLAG),
  .RTL_ACTIVE(RTL_ACTIVE), .IRQ(IRQ));

// [rlsb_gpib_ctl.sv]
// Behavioural instrument bus controller driving the remote/local inputs
`timescale 1ns/10ps
module rlsb_gpib_ctl (
  input wire logic clk,
  output logic ren_n,
  output logic listen_addressed,
  output logic my_listen_addr,
  output logic llo_cmd,
  output logic gtl_cmd
);
  // Idle bus: remote enable released, no command in flight
  initial begin
    ren_n = 1'b1;
    listen_addressed = 1'b0;
    my_listen_addr = 1'b0;
    llo_cmd = 1'b0;
    gtl_cmd = 1'b0;
  end

  // Remote enable level, held until changed again
  task automatic ren_set(input logic on);
    @(posedge clk);
    ren_n <= !on;
  endtask

  // One-cycle command; addressing shown only around the command
  task automatic send(input int kind, input logic adr);
    @(posedge clk);
    listen_addressed <= adr;
    my_listen_addr <= (kind == 0);
    llo_cmd <= (kind == 1);
    gtl_cmd <= (kind == 2);
    @(posedge clk);
    listen_addressed <= 1'b0;
    my_listen_addr <= 1'b0;
    llo_cmd <= 1'b0;
    gtl_cmd <= 1'b0;
  endtask
endmodule // rlsb_gpib_ctl

// [test_remote_local_status_block.sv]
// Self-checking bench with a reference model for the remote/local status block
`timescale 1ns/10ps
`include "rlsb_defs.svh"
module test_remote_local_status_block;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [3:0] PSTRB = 4'hF;
  logic [3:0] stb = 4'hF;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, REN_N, LISTEN_ADDRESSED, MY_LISTEN_ADDR, LOCAL_LOCKOUT_CMD, GO_TO_LOCAL_CMD;
  logic LOCKOUT_FLAG, HOST_CONTROLLED_FLAG, RTL_ACTIVE, IRQ;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  int seq [20] = '{0, 2, 3, 4, 5, 2, 1, 0, 2, 6, 2, 7, 2, 7, 2, 3, 6, 7, 4, 1};
  logic [31:0] seed = 32'h3a62_2abe;
  logic [31:0] rd, r;
  logic er;
  logic lk = 0, rm = 0, lchg = 0, rchg = 0, sel = 0, held = 0, ren = 0;
  logic [7:0] mask = 8'h00;
  localparam logic [7:0] A_ST = `RLSB_ADDR_INT_TWO;
  localparam logic [7:0] A_AUX = `RLSB_ADDR_AUX_CMD;
  localparam logic [7:0] A_CHG = `RLSB_ADDR_CHG_STATUS;

  rlsb_top dut (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .REN_N(REN_N),
    .LISTEN_ADDRESSED(LISTEN_ADDRESSED), .MY_LISTEN_ADDR(MY_LISTEN_ADDR), .LOCAL_LOCKOUT_CMD(LOCAL_LOCKOUT_CMD),
    .GO_TO_LOCAL_CMD(GO_TO_LOCAL_CMD), .LOCKOUT_FLAG(LOCKOUT_FLAG), .HOST_CONTROLLED_FLAG(HOST_CONTROLLED_FLAG),
    .RTL_ACTIVE(RTL_ACTIVE), .IRQ(IRQ));
  rlsb_gpib_ctl ctl (.clk(CLK), .ren_n(REN_N), .listen_addressed(LISTEN_ADDRESSED), .my_listen_addr(MY_LISTEN_ADDR),
    .llo_cmd(LOCAL_LOCKOUT_CMD), .gtl_cmd(GO_TO_LOCAL_CMD));

  // Clock and hang guard; the ceiling is far above the expected run
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      miscompares++;
      summarize();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // APB transfer; waits for the slave, and only the bench timeout ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= stb;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Settle, compare pins, then read status; a read with select clear empties the flags
  task automatic chk();
    repeat (8) @(posedge CLK);
    cmp_pin(LOCKOUT_FLAG, lk);
    cmp_pin(HOST_CONTROLLED_FLAG, rm);
    cmp_pin(RTL_ACTIVE, held);
    cmp_pin(IRQ, (lchg & mask[2]) | (rchg & mask[1]));
    apb(1'b0, A_ST, 32'h0000_0000);
    cmp_reg(rd, {26'h0, lk, rm, 1'b0, lchg, rchg, 1'b0});
    if (!sel) begin
      lchg = 0;
      rchg = 0;
    end
  endtask

  // One stimulus event applied to design and model alike
  task automatic ev(input int e);
    logic olk, orm;
    olk = lk;
    orm = rm;
    case (e)
      0: begin ctl.ren_set(1'b1); ren = 1; end
      1: begin ctl.ren_set(1'b0); ren = 0; lk = 0; rm = 0; end
      2: begin ctl.send(0, 1'b1); if (ren && (lk || !held)) rm = 1; end
      3: begin ctl.send(1, 1'b0); if (ren) lk = 1; end
      4: begin ctl.send(2, 1'b1); rm = 0; end
      5: ctl.send(2, 1'b0);
      6: begin apb(1'b1, A_AUX, 32'h0000_000D); held = 1; if (!lk) rm = 0; end
      default: begin apb(1'b1, A_AUX, 32'h0000_0005); if (!held && !lk) rm = 0; held = 0; end
    endcase
    if (lk != olk) lchg = 1;
    if (rm != orm) rchg = 1;
    chk();
  endtask

  // Main sequence: reset, directed walk, select mode, random mix
  initial begin
    repeat (6) @(posedge CLK);
    NRST <= 1'b1;
    chk();
    apb(1'b0, 8'h20, 32'h0000_0000);
    cmp_pin(er, 1'b1);
    cmp_reg(rd, 32'h0000_0000);
    // A write with byte strobe 0 clear is dropped
    stb = 4'hE;
    apb(1'b1, A_AUX, 32'h0000_000D);
    stb = 4'hF;
    chk();
    apb(1'b1, A_ST, 32'h0000_0006);
    mask = 8'h06;
    foreach (seq[i]) ev(seq[i]);
    apb(1'b1, A_AUX, 32'h0000_00E1);
    sel = 1;
    ev(0);
    ev(3);
    ev(2);
    apb(1'b1, A_AUX, 32'h0000_0059);
    lchg = 0;
    chk();
    apb(1'b1, A_AUX, 32'h0000_005A);
    rchg = 0;
    chk();
    ev(1);
    ev(6);
    apb(1'b0, A_CHG, 32'h0000_0000);
    cmp_reg(rd, {29'h0, lchg, rchg, held});
    apb(1'b1, A_CHG, 32'h0000_0006);
    lchg = 0;
    rchg = 0;
    apb(1'b1, A_AUX, 32'h0000_00E0);
    sel = 0;
    chk();
    // With select clear the clear command must leave the flag alone
    ev(0);
    ctl.send(1, 1'b0);
    lk = 1;
    lchg = 1;
    repeat (8) @(posedge CLK);
    apb(1'b1, A_AUX, 32'h0000_0059);
    apb(1'b0, A_CHG, 32'h0000_0000);
    cmp_reg(rd, {29'h0, lchg, rchg, held});
    chk();
    repeat (40) begin
      r = rnd();
      if (r[3:0] == 4'h0) begin
        apb(1'b1, A_ST, {24'h0, r[15:8]});
        mask = r[15:8];
        chk();
      end else ev(int'(r[6:4]));
    end
    apb(1'b1, A_ST, 32'h0000_0000);
    mask = 8'h00;
    chk();
    summarize();
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
endmodule // test_remote_local_status_block
